// [dv/eeetx_link_sink.sv]
// Link-side sink model that takes MAC words with random stalls
module eeetx_link_sink #(
  parameter int DATA_W = 64
) (
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic              out_valid,
  input  wire logic [DATA_W-1:0] out_data,
  output logic                   out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] rx_q[$];
  // Ready changes by nonblocking update on the edge; gaps model a slow partner
  initial out_ready = 1'b0;
  always @(posedge clk) begin
    out_ready <= !stall && ($urandom_range(3) != 0);
  end
  // A word counts only at an edge where both sides agree
  always @(posedge clk) begin
    if (out_valid && out_ready) rx_q.push_back(out_data);
  end
endmodule

// [dv/eeetx_sched_tb.sv]
// Self-checking bench for the EEE transmit wake scheduler
`include "eeetx_map.svh"
module eeetx_sched_tb
  import eeetx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, eee_en, autoneg_done, full_duplex, stall;
  logic        in_valid, in_ready, out_valid, out_ready, tx_power_down, tx_waking;
  logic [1:0]  link_speed;
  logic [7:0]  urgent_sel, q_pending;
  logic [15:0] pending_bytes;
  logic [63:0] in_data, out_data, w;
  logic [8:0]  wake_cycles;
  int          n_mismatch, num_checks, k;
  logic [63:0] sent_q[$];
  eeetx_sched u_eeetx_sched (.clk(clk), .rst_b(rst_b), .eee_en(eee_en),
    .autoneg_done(autoneg_done), .full_duplex(full_duplex), .link_speed(link_speed),
    .urgent_sel(urgent_sel), .q_pending(q_pending), .pending_bytes(pending_bytes),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .tx_power_down(tx_power_down),
    .tx_waking(tx_waking), .wake_cycles(wake_cycles));
  eeetx_link_sink u_eeetx_link_sink (.clk(clk), .stall(stall), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));
  // Expected wake length in cycles from the link speed
  function automatic logic [8:0] exp_wake(input logic [1:0] spd);
    if (spd == `EEETX_SPD_1G) return 9'(`EEETX_WAKE_GIG_NS / `EEETX_CLK_PERIOD_NS);
    return 9'(`EEETX_WAKE_OTH_NS / `EEETX_CLK_PERIOD_NS);
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tdone(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Holds the word until the edge that takes it; valid stays up so that
  // back-to-back calls never drop and raise it in one time step
  task automatic send(input logic [63:0] d);
    in_valid = 1'b1;
    in_data = d;
    while (!in_ready) @(negedge clk);
    @(negedge clk);
    sent_q.push_back(d);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Bound of several times the planned run
  initial begin
    #(20000 * 100);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {rst_b, in_valid, stall, urgent_sel, q_pending, pending_bytes, in_data} = '0;
    {eee_en, autoneg_done, full_duplex, link_speed} = {3'h7, `EEETX_SPD_1G};
    w = 64'(int'($urandom(32'hc336)));
    cyc(1);
    check(64'({tx_power_down, tx_waking, in_ready, out_valid}), 64'h0002);
    check(64'(wake_cycles), 64'h012c);
    cyc(1);
    rst_b = 1'b1;
    cyc(5);
    check(64'(tx_power_down), 64'h0001);
    tdone("sleep");
    // Urgent wake at both eligible speeds
    for (int i = 0; i < 2; i++) begin
      link_speed = (i == 0) ? `EEETX_SPD_1G : `EEETX_SPD_100M;
      cyc(3);
      check(64'(tx_power_down), 64'h0001);
      urgent_sel = 8'h01 << $urandom_range(7);
      q_pending = urgent_sel;
      cyc(1);
      check(64'({tx_waking, tx_power_down}), 64'h0002);
      check(64'(wake_cycles), 64'(exp_wake(link_speed)));
      cyc(int'(exp_wake(link_speed)) - 1);
      check(64'(tx_waking), 64'h0001);
      cyc(1);
      check(64'(tx_waking), 64'h0000);
      {q_pending, urgent_sel} = '0;
      cyc(2);
      check(64'(tx_power_down), 64'h0001);
    end
    tdone("urgent");
    // Byte threshold boundary; urgent mark on another queue must not help
    {pending_bytes, q_pending, urgent_sel} = {16'h0bb7, 8'h01, 8'h02};
    cyc(20);
    check(64'(tx_power_down), 64'h0001);
    pending_bytes = 16'h0bb8;
    cyc(2);
    check(64'(tx_waking), 64'h0001);
    cyc(305);
    q_pending = '0;
    cyc(2);
    tdone("threshold");
    // Deferral timer for a small random backlog
    pending_bytes = 16'($urandom_range(2999));
    q_pending = 8'h01 << $urandom_range(7);
    urgent_sel = '0;
    cyc(`EEETX_DEFER_NS / `EEETX_CLK_PERIOD_NS);
    check(64'(tx_power_down), 64'h0001);
    cyc(1);
    check(64'(tx_waking), 64'h0001);
    cyc(305);
    q_pending = '0;
    cyc(2);
    check(64'(tx_power_down), 64'h0001);
    tdone("timer");
    // Each ineligible mode keeps the port powered
    for (k = 0; k < 4; k++) begin
      {eee_en, autoneg_done, full_duplex} = {k != 0, k != 1, k != 2};
      link_speed = (k == 3) ? `EEETX_SPD_10M : `EEETX_SPD_100M;
      cyc(310);
      check(64'(tx_power_down), 64'h0000);
      {eee_en, autoneg_done, full_duplex, link_speed} = {3'h7, `EEETX_SPD_100M};
      cyc(3);
      check(64'(tx_power_down), 64'h0001);
    end
    tdone("eligibility");
    // Stream on a disabled port: fill until refused, then drain in order
    eee_en = 1'b0;
    stall = 1'b1;
    cyc(310);
    send({$urandom, $urandom});
    send({$urandom, $urandom});
    in_valid = 1'b0;
    check(64'(in_ready), 64'h0000);
    stall = 1'b0;
    repeat (6) send({$urandom, $urandom});
    in_valid = 1'b0;
    cyc(20);
    check(64'(u_eeetx_link_sink.rx_q.size()), 64'(sent_q.size()));
    foreach (sent_q[i]) check(u_eeetx_link_sink.rx_q[i], sent_q[i]);
    tdone("stream");
    // A word buffered while asleep waits out deferral and wake
    eee_en = 1'b1;
    cyc(3);
    send(w);
    in_valid = 1'b0;
    check(64'(out_valid), 64'h0000);
    check(64'(tx_power_down), 64'h0001);
    cyc(800);
    check(64'(u_eeetx_link_sink.rx_q.size()), 64'(sent_q.size()));
    check(u_eeetx_link_sink.rx_q[$], w);
    tdone("held");
    give_verdict();
  end
endmodule

// [rtl/eeetx_map.svh]
// Timing, threshold and speed-code constants for the EEE transmit wake scheduler
// What this block does
// R1 - Idle enabled port powers transmit down, wakes for data
// R2 - Wake interval 17 us gigabit, 30 us otherwise
// R3 - Both link ends use the same wake interval
// R4 - Non-urgent data deferred until 3000 bytes pending
// R5 - Deferred data still wakes after 48 us
// R6 - Urgent queue data starts wakeup immediately
// R7 - Per-queue urgent selection; others use byte deferral
// R8 - Per-port enable; disabled port never sleeps
// R9 - Sleep only on autoneg full duplex 1G/100M
// R10 - Deferral timer starts on first data, clears on wake
`ifndef EEETX_MAP_SVH
`define EEETX_MAP_SVH
`define EEETX_CLK_PERIOD_NS 100
`define EEETX_WAKE_GIG_NS   17000
`define EEETX_WAKE_OTH_NS   30000
`define EEETX_DEFER_NS      48000
`define EEETX_BYTE_THR      3000
`define EEETX_SPD_10M       2'h0
`define EEETX_SPD_100M      2'h1
`define EEETX_SPD_1G        2'h2
`define EEETX_BUF_DEPTH     2
`endif

// [rtl/eeetx_pkg.sv]
// Types shared by the EEE transmit wake scheduler
package eeetx_pkg;
  // Power state of one port's transmit path
  typedef enum logic [1:0] {
    EEETX_ACTIVE,
    EEETX_SLEEP,
    EEETX_DEFER,
    EEETX_WAKE
  } eeetx_state_t;
endpackage

// [rtl/eeetx_sched.sv]
// One port's EEE transmit scheduler with a two-entry egress buffer
`include "eeetx_map.svh"
module eeetx_sched
  import eeetx_pkg::*;
#(
  parameter int NQ     = 8,
  parameter int DATA_W = 64,
  parameter int BYTE_W = 16,
  parameter int BYTE_THR = `EEETX_BYTE_THR
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              eee_en,
  input  wire logic              autoneg_done,
  input  wire logic              full_duplex,
  input  wire logic [1:0]        link_speed,
  input  wire logic [NQ-1:0]     urgent_sel,
  input  wire logic [NQ-1:0]     q_pending,
  input  wire logic [BYTE_W-1:0] pending_bytes,
  input  wire logic              in_valid,
  input  wire logic [DATA_W-1:0] in_data,
  output logic                   in_ready,
  output logic                   out_valid,
  output logic [DATA_W-1:0]      out_data,
  input  wire logic              out_ready,
  output logic                   tx_power_down,
  output logic                   tx_waking,
  output logic [8:0]             wake_cycles
);
  // Derived cycle counts; least times round up
  localparam int WAKE_GIG_CYC =
    (`EEETX_WAKE_GIG_NS + `EEETX_CLK_PERIOD_NS - 1) / `EEETX_CLK_PERIOD_NS;
  localparam int WAKE_OTH_CYC =
    (`EEETX_WAKE_OTH_NS + `EEETX_CLK_PERIOD_NS - 1) / `EEETX_CLK_PERIOD_NS;
  localparam int DEFER_CYC =
    (`EEETX_DEFER_NS + `EEETX_CLK_PERIOD_NS - 1) / `EEETX_CLK_PERIOD_NS;
  localparam int DEPTH = `EEETX_BUF_DEPTH;

  logic               rst_s1_reg;
  logic               rst_n;
  eeetx_state_t       state_reg;
  eeetx_state_t       state_next;
  logic [8:0]         defer_cnt_reg;
  logic [8:0]         wake_cnt_reg;
  logic [8:0]         wake_len_reg;
  logic [DATA_W-1:0]  mem_reg [DEPTH];
  logic               wr_ptr_reg;
  logic               rd_ptr_reg;
  logic [1:0]         count_reg;
  logic               eligible;
  logic               any_pend;
  logic               urgent_pend;
  logic               thr_hit;
  logic               timer_hit;
  logic               push;
  logic               pop;

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Port qualifies for low power only in these link modes
  assign eligible = eee_en && autoneg_done && full_duplex &&      // [R8] [R9]
                    (link_speed == `EEETX_SPD_1G || link_speed == `EEETX_SPD_100M);
  assign any_pend    = (|q_pending) || in_valid || (count_reg != 2'h0);
  assign urgent_pend = |(q_pending & urgent_sel);                  // [R7]
  assign thr_hit     = pending_bytes >= BYTE_W'(BYTE_THR);         // [R4]
  assign timer_hit   = defer_cnt_reg >= 9'(DEFER_CYC - 1);         // [R5]

  // Power state decisions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EEETX_ACTIVE:
        if (eligible && !any_pend) begin
          state_next = EEETX_SLEEP;                                // [R1]
        end
      EEETX_SLEEP:
        if (!eligible || urgent_pend) begin
          state_next = EEETX_WAKE;                                 // [R6] [R8]
        end else if (any_pend) begin
          state_next = thr_hit ? EEETX_WAKE : EEETX_DEFER;         // [R4] [R10]
        end
      EEETX_DEFER:
        // Whichever trigger comes first ends the deferral
        if (!eligible || urgent_pend || thr_hit || timer_hit) begin
          state_next = EEETX_WAKE;                                 // [R10]
        end
      EEETX_WAKE:
        if (wake_cnt_reg == wake_len_reg - 9'h001) begin
          state_next = EEETX_ACTIVE;                               // [R2]
        end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= EEETX_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Deferral timer, zero outside the deferral state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      defer_cnt_reg <= 9'h000;
    end else if (state_reg == EEETX_DEFER && state_next == EEETX_DEFER) begin
      defer_cnt_reg <= defer_cnt_reg + 9'h001;                     // [R10]
    end else begin
      defer_cnt_reg <= 9'h000;
    end
  end

  // Wake length latched on entry so a speed change mid-wake is harmless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_len_reg <= 9'(WAKE_OTH_CYC);
      wake_cnt_reg <= 9'h000;
    end else if (state_reg != EEETX_WAKE && state_next == EEETX_WAKE) begin
      wake_len_reg <= (link_speed == `EEETX_SPD_1G) ? 9'(WAKE_GIG_CYC)
                                                   : 9'(WAKE_OTH_CYC); // [R2] [R3]
      wake_cnt_reg <= 9'h000;
    end else if (state_reg == EEETX_WAKE) begin
      wake_cnt_reg <= wake_cnt_reg + 9'h001;
    end
  end

  // Status outputs from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_power_down <= 1'b0;
      tx_waking     <= 1'b0;
    end else begin
      tx_power_down <= (state_next == EEETX_SLEEP) || (state_next == EEETX_DEFER); // [R1]
      tx_waking     <= (state_next == EEETX_WAKE);
    end
  end
  assign wake_cycles = wake_len_reg;

  // Two-entry buffer; drains only when fully powered
  assign in_ready  = count_reg != 2'(DEPTH);
  assign out_valid = (count_reg != 2'h0) && (state_reg == EEETX_ACTIVE); // [R1]
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Buffer storage is data only, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Buffer pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + 2'(push) - 2'(pop);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter_wake;
    state_reg != EEETX_WAKE ##1 state_reg == EEETX_WAKE;
  endsequence
  sequence s_leave_wake;
    state_reg == EEETX_WAKE ##1 state_reg == EEETX_ACTIVE;
  endsequence

  property p_idle_sleeps;
    state_reg == EEETX_ACTIVE && eligible && !any_pend |=> tx_power_down;
  endproperty
  a_idle_sleeps: assert property (p_idle_sleeps) // [R1]
    else $error("idle eligible port did not power down");

  property p_wake_length;
    s_leave_wake |-> $past(wake_cnt_reg) == wake_len_reg - 9'h001;
  endproperty
  a_wake_length: assert property (p_wake_length) // [R2]
    else $error("wake interval length wrong");

  property p_wake_speed;
    s_enter_wake |-> wake_len_reg == (($past(link_speed) == `EEETX_SPD_1G) ?
                     9'(WAKE_GIG_CYC) : 9'(WAKE_OTH_CYC));
  endproperty
  a_wake_speed: assert property (p_wake_speed) // [R3]
    else $error("wake interval does not match link speed");

  property p_defer_holds;
    state_reg == EEETX_DEFER && eligible && !urgent_pend && !thr_hit && !timer_hit
      |=> state_reg == EEETX_DEFER && tx_power_down;
  endproperty
  a_defer_holds: assert property (p_defer_holds) // [R4]
    else $error("deferral ended early");

  property p_timeout;
    state_reg == EEETX_DEFER && defer_cnt_reg == 9'(DEFER_CYC - 1)
      |=> state_reg == EEETX_WAKE;
  endproperty
  a_timeout: assert property (p_timeout) // [R5]
    else $error("deferral timeout did not wake");

  property p_urgent;
    (state_reg == EEETX_SLEEP || state_reg == EEETX_DEFER) && urgent_pend
      |=> state_reg == EEETX_WAKE ##1 tx_waking;
  endproperty
  a_urgent: assert property (p_urgent) // [R6]
    else $error("urgent data did not start wakeup");

  property p_unselected;
    state_reg == EEETX_SLEEP && eligible && (|q_pending) && !urgent_pend && !thr_hit
      |=> state_reg == EEETX_DEFER;
  endproperty
  a_unselected: assert property (p_unselected) // [R7]
    else $error("unselected queue woke without threshold");

  property p_disabled;
    !eee_en && state_reg == EEETX_ACTIVE |=> !tx_power_down;
  endproperty
  a_disabled: assert property (p_disabled) // [R8]
    else $error("disabled port powered down");

  property p_mode;
    (link_speed == `EEETX_SPD_10M || !full_duplex || !autoneg_done)
      && state_reg == EEETX_ACTIVE |=> state_reg == EEETX_ACTIVE;
  endproperty
  a_mode: assert property (p_mode) // [R9]
    else $error("ineligible link mode entered low power");

  property p_timer_start;
    state_reg == EEETX_SLEEP ##1 state_reg == EEETX_DEFER |-> defer_cnt_reg == 9'h000;
  endproperty
  a_timer_start: assert property (p_timer_start) // [R10]
    else $error("deferral timer not cleared at start");
endmodule
